//--- rtl/dds_tuning_word_path.sv
`timescale 1ns/1ps
`default_nettype none
module dds_tuning_word_path
  import dds_tuning_pkg::*;
#(
  parameter int unsigned CYCLES_PER_MS = MS_CYCLES
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire reg_req_t reg_req_i,
  output logic [DATA_W-1:0] reg_rdata_o,
  output logic reg_rvalid_o,
  input wire loop_mode_t loop_mode_i,
  input wire logic [FTW_W-1:0] lf_word_i,
  input wire logic lf_valid_i,
  input wire logic ref_switch_i,
  input wire logic mfp_clear_history_i,
  output logic [PHASE_W-1:0] phase_word_o,
  output logic [FTW_W-1:0] tuning_word_o,
  output logic [DAC_W-1:0] dac_current_code_o,
  output logic history_strobe_o,
  output logic history_valid_o
);

  localparam int DIV_LAT = SUM_W + 1;

  logic [FTW_W-1:0] free_run_q;
  logic [CLAMP_W-1:0] clamp_upper_q;
  logic [CLAMP_W-1:0] clamp_lower_q;
  logic [PHASE_W-1:0] phase_offset_q;
  logic [DAC_W-1:0] dac_q;
  logic [INTERVAL_W-1:0] interval_q;
  hist_ctrl_t hist_ctrl_q;
  logic [DATA_W-1:0] rdata_d;
  logic [DATA_W-1:0] rdata_q;
  logic rvalid_q;
  logic clear_sw;

  logic [FTW_W-1:0] acc_q;
  logic [FTW_W-1:0] selected_word;
  logic [FTW_W-1:0] active_word;
  logic [FTW_W-1:0] upper_word;
  logic [FTW_W-1:0] lower_word;
  logic [FTW_W-1:0] tw_q;
  logic [PHASE_W-1:0] phase_q;
  logic [FTW_W-1:0] last_sample_q;

  logic mfp_sync1_q;
  logic mfp_sync2_q;
  logic mfp_prev_q;
  logic clear_req;
  logic erase;
  logic restart;

  logic [MS_CNT_W-1:0] ms_cnt_q;
  logic ms_tick;
  logic [INTERVAL_W-1:0] elapsed_q;
  logic [INTERVAL_W-1:0] elapsed_next;
  logic first_q;
  logic [K_W-1:0] shift_q;
  logic [SUM_W-1:0] sum_q;
  logic [CNT_W-1:0] cnt_q;
  logic take_sample;
  logic full_end;
  logic inter_end;
  logic div_go;

  div_state_t div_state_q;
  logic [SUM_W-1:0] dvd_q;
  logic [CNT_W-1:0] dsr_q;
  logic [CNT_W:0] rem_q;
  logic [STEP_W-1:0] step_q;
  logic [CNT_W:0] rem_shift;
  logic rem_ge;
  logic [SUM_W-1:0] dvd_next;
  logic [FTW_W-1:0] hist_word_q;
  logic hist_valid_q;
  logic strobe_q;
  logic abort_seen_q;

  // Registers are byte wide; multi-byte fields keep their low byte at the lowest offset.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      free_run_q <= FREE_RUN_RESET;
      clamp_upper_q <= CLAMP_UPPER_RESET;
      clamp_lower_q <= CLAMP_LOWER_RESET;
      phase_offset_q <= PHASE_RESET;
      dac_q <= DAC_RESET;
      interval_q <= INTERVAL_RESET;
      hist_ctrl_q <= HIST_CTRL_RESET;
    end else if (reg_req_i.we) begin
      for (int i = 0; i < FTW_BYTES; i++) begin
        if (reg_req_i.addr == ADDR_FREE_RUN + ADDR_W'(i)) begin
          free_run_q[8*i +: 8] <= reg_req_i.wdata;
        end
      end
      for (int i = 0; i < CLAMP_BYTES; i++) begin
        if (reg_req_i.addr == ADDR_CLAMP_UPPER + ADDR_W'(i)) begin
          clamp_upper_q[8*i +: 8] <= reg_req_i.wdata;
        end else if (reg_req_i.addr == ADDR_CLAMP_LOWER + ADDR_W'(i)) begin
          clamp_lower_q[8*i +: 8] <= reg_req_i.wdata;
        end else if (reg_req_i.addr == ADDR_INTERVAL + ADDR_W'(i)) begin
          interval_q[8*i +: 8] <= reg_req_i.wdata;
        end
      end
      for (int i = 0; i < PHASE_BYTES; i++) begin
        if (reg_req_i.addr == ADDR_PHASE_OFFSET + ADDR_W'(i)) begin
          phase_offset_q[8*i +: 8] <= reg_req_i.wdata;
        end
      end
      if (reg_req_i.addr == ADDR_DAC_LO) begin
        dac_q[DATA_W-1:0] <= reg_req_i.wdata;
      end else if (reg_req_i.addr == ADDR_DAC_HI) begin
        dac_q[DAC_W-1:DATA_W] <= reg_req_i.wdata[DAC_HI_BITS-1:0];
      end else if (reg_req_i.addr == ADDR_HIST_CTRL) begin
        hist_ctrl_q <= reg_req_i.wdata;
      end
    end
  end

  assign clear_sw = reg_req_i.we && (reg_req_i.addr == ADDR_HIST_CLEAR) &&
                    reg_req_i.wdata[CLEAR_HISTORY_BIT];

  // The clear bit is a one-shot command, so it always reads back as zero.
  always_comb begin
    rdata_d = BYTE_ZERO;
    if (reg_req_i.addr == ADDR_DAC_LO) begin
      rdata_d = dac_q[DATA_W-1:0];
    end else if (reg_req_i.addr == ADDR_DAC_HI) begin
      rdata_d = {{(DATA_W-DAC_HI_BITS){1'b0}}, dac_q[DAC_W-1:DATA_W]};
    end else if (reg_req_i.addr == ADDR_HIST_CTRL) begin
      rdata_d = {3'b000, hist_ctrl_q.fallback, hist_ctrl_q.persistent, hist_ctrl_q.k};
    end
    for (int i = 0; i < FTW_BYTES; i++) begin
      if (reg_req_i.addr == ADDR_FREE_RUN + ADDR_W'(i)) begin
        rdata_d = free_run_q[8*i +: 8];
      end else if (reg_req_i.addr == ADDR_HIST_RESULT + ADDR_W'(i)) begin
        rdata_d = hist_word_q[8*i +: 8];
      end
    end
    for (int i = 0; i < CLAMP_BYTES; i++) begin
      if (reg_req_i.addr == ADDR_CLAMP_UPPER + ADDR_W'(i)) begin
        rdata_d = clamp_upper_q[8*i +: 8];
      end else if (reg_req_i.addr == ADDR_CLAMP_LOWER + ADDR_W'(i)) begin
        rdata_d = clamp_lower_q[8*i +: 8];
      end else if (reg_req_i.addr == ADDR_INTERVAL + ADDR_W'(i)) begin
        rdata_d = interval_q[8*i +: 8];
      end
    end
    for (int i = 0; i < PHASE_BYTES; i++) begin
      if (reg_req_i.addr == ADDR_PHASE_OFFSET + ADDR_W'(i)) begin
        rdata_d = phase_offset_q[8*i +: 8];
      end
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdata_q <= BYTE_ZERO;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= reg_req_i.re;
      if (reg_req_i.re) begin
        rdata_q <= rdata_d;
      end
    end
  end

  always_comb begin
    case (loop_mode_i)
      MODE_FREE_RUN: selected_word = free_run_q;
      MODE_CLOSED: selected_word = lf_word_i;
      MODE_HOLDOVER: begin
        if (hist_valid_q) begin
          selected_word = hist_word_q;
        end else if (hist_ctrl_q.fallback) begin
          selected_word = last_sample_q;
        end else begin
          selected_word = free_run_q;
        end
      end
      default: selected_word = free_run_q;
    endcase
  end

  assign upper_word = {clamp_upper_q, CLAMP_FILL_ONES};
  assign lower_word = {clamp_lower_q, CLAMP_FILL_ZEROS};
  always_comb begin
    if (selected_word > upper_word) begin
      active_word = upper_word;
    end else if (selected_word < lower_word) begin
      active_word = lower_word;
    end else begin
      active_word = selected_word;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      acc_q <= FREE_RUN_RESET;
      phase_q <= PHASE_RESET;
      tw_q <= FREE_RUN_RESET;
    end else begin
      acc_q <= acc_q + active_word;
      phase_q <= acc_q[FTW_W-1 -: PHASE_W] + phase_offset_q;
      tw_q <= active_word;
    end
  end

  // The pin is asynchronous; only its second stage feeds the edge detector.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mfp_sync1_q <= 1'b0;
      mfp_sync2_q <= 1'b0;
      mfp_prev_q <= 1'b0;
    end else begin
      mfp_sync1_q <= mfp_clear_history_i;
      mfp_sync2_q <= mfp_sync1_q;
      mfp_prev_q <= mfp_sync2_q;
    end
  end

  assign clear_req = clear_sw || (mfp_sync2_q && !mfp_prev_q);
  assign erase = clear_req || (ref_switch_i && !hist_ctrl_q.persistent);
  assign restart = clear_req || ref_switch_i;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ms_cnt_q <= '0;
    end else if (ms_cnt_q == MS_CNT_W'(CYCLES_PER_MS - 1)) begin
      ms_cnt_q <= '0;
    end else begin
      ms_cnt_q <= ms_cnt_q + MS_CNT_W'(1);
    end
  end
  assign ms_tick = (ms_cnt_q == MS_CNT_W'(CYCLES_PER_MS - 1));

  // zero interval relies on software.
  // A zero interval would end every millisecond tick; the compare stays defined.
  assign elapsed_next = elapsed_q + INTERVAL_ONE;
  assign full_end = ms_tick && (elapsed_next >= interval_q);
  assign inter_end = ms_tick && !full_end && first_q && (shift_q != '0) &&
                     (elapsed_next >= (interval_q >> shift_q));
  assign take_sample = (loop_mode_i == MODE_CLOSED) && lf_valid_i;
  assign div_go = (full_end || inter_end) && !restart && (cnt_q != '0) &&
                  (div_state_q == DIV_IDLE);

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      elapsed_q <= '0;
      first_q <= 1'b1;
      shift_q <= '0;
    end else if (restart) begin
      elapsed_q <= '0;
      if (erase) begin
        first_q <= 1'b1;
        shift_q <= hist_ctrl_q.k;
      end
    end else if (full_end) begin
      elapsed_q <= '0;
      first_q <= 1'b0;
    end else if (ms_tick) begin
      elapsed_q <= elapsed_next;
      if (inter_end) begin
        shift_q <= shift_q - K_W'(1);
      end
    end
  end

  // Intermediate averages keep summing; only a full interval end or a restart starts afresh.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sum_q <= '0;
      cnt_q <= '0;
      last_sample_q <= FREE_RUN_RESET;
    end else begin
      if (take_sample) begin
        last_sample_q <= lf_word_i;
      end
      if (restart || full_end) begin
        sum_q <= take_sample ? SUM_W'(lf_word_i) : '0;
        cnt_q <= take_sample ? CNT_ONE : '0;
      end else if (take_sample) begin
        sum_q <= sum_q + SUM_W'(lf_word_i);
        cnt_q <= cnt_q + CNT_ONE;
      end
    end
  end

  assign rem_shift = {rem_q[CNT_W-1:0], dvd_q[SUM_W-1]};
  assign rem_ge = (rem_shift >= {1'b0, dsr_q});
  assign dvd_next = {dvd_q[SUM_W-2:0], rem_ge};

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      div_state_q <= DIV_IDLE;
      dvd_q <= '0;
      dsr_q <= '0;
      rem_q <= '0;
      step_q <= '0;
    end else if (erase) begin
      div_state_q <= DIV_IDLE;
    end else begin
      case (div_state_q)
        DIV_IDLE: begin
          if (div_go) begin
            dvd_q <= sum_q;
            dsr_q <= cnt_q;
            rem_q <= '0;
            step_q <= '0;
            div_state_q <= DIV_RUN;
          end
        end
        DIV_RUN: begin
          dvd_q <= dvd_next;
          rem_q <= rem_ge ? (rem_shift - {1'b0, dsr_q}) : rem_shift;
          step_q <= step_q + STEP_W'(1);
          if (step_q == STEP_W'(SUM_W - 1)) begin
            div_state_q <= DIV_IDLE;
          end
        end
        default: div_state_q <= DIV_IDLE;
      endcase
    end
  end

  // An erase aborts a running divide so a stale mean never lands after the clear.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      hist_word_q <= FREE_RUN_RESET;
      hist_valid_q <= 1'b0;
      strobe_q <= 1'b0;
    end else begin
      strobe_q <= 1'b0;
      if (erase) begin
        hist_valid_q <= 1'b0;
      end else if (div_state_q == DIV_RUN && step_q == STEP_W'(SUM_W - 1)) begin
        hist_word_q <= dvd_next[FTW_W-1:0];
        hist_valid_q <= 1'b1;
        strobe_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      abort_seen_q <= 1'b0;
    end else if (div_go) begin
      abort_seen_q <= 1'b0;
    end else if (erase) begin
      abort_seen_q <= 1'b1;
    end
  end

  assign reg_rdata_o = rdata_q;
  assign reg_rvalid_o = rvalid_q;
  assign phase_word_o = phase_q;
  assign tuning_word_o = tw_q;
  assign dac_current_code_o = dac_q;
  assign history_strobe_o = strobe_q;
  assign history_valid_o = hist_valid_q;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!reset_n_i);

  sequence s_divide_started;
    div_go;
  endsequence

  sequence s_result_or_abort;
    history_strobe_o || abort_seen_q;
  endsequence

  AST_ACC_STEP: assert property (acc_q == $past(acc_q) + $past(active_word))
    else $error("Accumulator did not advance by the tuning word.");

  AST_ACC_WRAP: assert property ($past(acc_q) > acc_q |-> $past(active_word) != '0)
    else $error("Accumulator wrapped without a step.");

  AST_PHASE_OUT: assert property (##1 phase_word_o == PHASE_W'($past(acc_q[FTW_W-1 -: PHASE_W]) + $past(phase_offset_q)))
    else $error("Phase output is not accumulator plus offset.");

  AST_DAC_CODE: assert property ($changed(dac_current_code_o) |-> $past(reg_req_i.we))
    else $error("Converter code changed without a register write.");

  AST_FREE_RUN: assert property (loop_mode_i == MODE_FREE_RUN |-> selected_word == free_run_q)
    else $error("Free-run mode does not use the free-run word.");

  AST_CLOSED: assert property (loop_mode_i == MODE_CLOSED |=> tuning_word_o == $past(active_word) && ($past(lf_word_i) >= $past(lower_word) && $past(lf_word_i) <= $past(upper_word) -> tuning_word_o == $past(lf_word_i)))
    else $error("Closed loop does not pass the loop filter word.");

  AST_HOLD_HIST: assert property (loop_mode_i == MODE_HOLDOVER && hist_valid_q |-> selected_word == hist_word_q)
    else $error("Holdover with history does not use the average.");

  AST_FALLBACK: assert property (loop_mode_i == MODE_HOLDOVER && !hist_valid_q |-> selected_word == (hist_ctrl_q.fallback ? last_sample_q : free_run_q))
    else $error("Holdover fallback picks the wrong word.");

  AST_CLAMP: assert property (##1 tuning_word_o <= $past(upper_word) && tuning_word_o >= $past(lower_word))
    else $error("Tuning word escaped the clamp limits.");

  AST_DIVIDE_LATENCY: assert property (s_divide_started |-> ##DIV_LAT s_result_or_abort)
    else $error("Average not stored on time after interval end.");

  AST_STROBE_PULSE: assert property (history_strobe_o |-> history_valid_o ##1 !history_strobe_o)
    else $error("History strobe is not a single cycle with valid history.");

  AST_CLEAR: assert property (clear_req |=> !history_valid_o && !history_strobe_o)
    else $error("History not erased after clear request.");

  AST_SWITCH_KEEP: assert property (ref_switch_i && hist_ctrl_q.persistent && !clear_req && hist_valid_q |=> history_valid_o)
    else $error("Persistent history lost on switchover.");

  AST_NO_EARLY: assert property (inter_end |-> first_q && shift_q != '0 && elapsed_next < interval_q)
    else $error("Intermediate average outside the first interval.");

endmodule
`default_nettype wire

//--- rtl/dds_tuning_pkg.sv
// Operation
// - Add the 48-bit tuning step word to the phase accumulator every clock.
// - Accumulator wraps modulo 2^48 and keeps the excess past the wrap.
// - Add the 16-bit phase offset from 0x030D/0x030E to the accumulator output.
// - Offset counts in 1/65536 of an output cycle.
// - Hold the 10-bit converter current code at 0x0213/0x0214 and drive it out.
// - Free-run mode feeds the free-run tuning word from 0x0300 to 0x0305.
// - Closed loop feeds the live loop filter output.
// - Holdover feeds the word derived from recorded closed-loop history.
// - Always clamp the word between 24-bit limits at 0x0307 to 0x030C.
// - A limit N stands for sample rate times N over 2^24.
// - After reset the limits span zero up to the sample rate.
// - Average over a 24-bit millisecond interval at 0x0318, at least 1 ms.
// - Each interval end writes the average into read-only 0x0D14 to 0x0D19.
// - Each average uses only its own interval's samples.
// - Each interval end emits a one-cycle strobe for status and pins.
// - A new reference restarts history, erasing it unless 0x031B bit 3 is set.
// - Writing 0x0A03 bit 2 or the pin request erases the history.
// - With no history, the first value waits a full interval unless K is set; K is loaded whenever history is erased, not at reset.
// - After a clear, K gives K early averages at interval over 2^K upward.
// - K of zero gives no early averages.
// - After the first interval, averages come every full interval.
// - Holdover without history uses free-run word, or last sample if bit 4 set.
package dds_tuning_pkg;

  localparam int unsigned FTW_W = 48;
  localparam int unsigned PHASE_W = 16;
  localparam int unsigned DAC_W = 10;
  localparam int unsigned CLAMP_W = 24;
  localparam int unsigned INTERVAL_W = 24;
  localparam int unsigned K_W = 3;
  localparam int unsigned CNT_W = 40;
  localparam int unsigned SUM_W = FTW_W + CNT_W;
  localparam int unsigned STEP_W = 7;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned MS_CNT_W = 32;

  localparam int unsigned FTW_BYTES = 6;
  localparam int unsigned CLAMP_BYTES = 3;
  localparam int unsigned PHASE_BYTES = 2;
  localparam int unsigned INTERVAL_BYTES = 3;

  localparam logic [ADDR_W-1:0] ADDR_DAC_LO = 12'h213;
  localparam logic [ADDR_W-1:0] ADDR_DAC_HI = 12'h214;
  localparam logic [ADDR_W-1:0] ADDR_FREE_RUN = 12'h300;
  localparam logic [ADDR_W-1:0] ADDR_CLAMP_UPPER = 12'h307;
  localparam logic [ADDR_W-1:0] ADDR_CLAMP_LOWER = 12'h30a;
  localparam logic [ADDR_W-1:0] ADDR_PHASE_OFFSET = 12'h30d;
  localparam logic [ADDR_W-1:0] ADDR_INTERVAL = 12'h318;
  localparam logic [ADDR_W-1:0] ADDR_HIST_CTRL = 12'h31b;
  localparam logic [ADDR_W-1:0] ADDR_HIST_CLEAR = 12'ha03;
  localparam logic [ADDR_W-1:0] ADDR_HIST_RESULT = 12'hd14;

  localparam int unsigned CLEAR_HISTORY_BIT = 2;
  localparam int unsigned DAC_HI_BITS = DAC_W - DATA_W;

  localparam logic [FTW_W-1:0] FREE_RUN_RESET = 48'h0000_0000_0000;
  localparam logic [CLAMP_W-1:0] CLAMP_UPPER_RESET = 24'hff_ffff;
  localparam logic [CLAMP_W-1:0] CLAMP_LOWER_RESET = 24'h00_0000;
  localparam logic [CLAMP_W-1:0] CLAMP_FILL_ONES = 24'hff_ffff;
  localparam logic [CLAMP_W-1:0] CLAMP_FILL_ZEROS = 24'h00_0000;
  localparam logic [PHASE_W-1:0] PHASE_RESET = 16'h0000;
  localparam logic [DAC_W-1:0] DAC_RESET = 10'h000;
  localparam logic [INTERVAL_W-1:0] INTERVAL_RESET = 24'h00_0001;
  localparam logic [INTERVAL_W-1:0] INTERVAL_ONE = 24'h00_0001;
  localparam logic [CNT_W-1:0] CNT_ONE = 40'h00_0000_0001;
  localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;

  localparam int unsigned MS_TIME_NS = 1_000_000;
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned MS_CYCLES = MS_TIME_NS / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    MODE_FREE_RUN = 3'b001,
    MODE_CLOSED = 3'b010,
    MODE_HOLDOVER = 3'b100
  } loop_mode_t;

  typedef enum logic [1:0] {
    DIV_IDLE = 2'b01,
    DIV_RUN = 2'b10
  } div_state_t;

  typedef struct packed {
    logic [2:0] unused;
    logic fallback;
    logic persistent;
    logic [K_W-1:0] k;
  } hist_ctrl_t;

  localparam hist_ctrl_t HIST_CTRL_RESET = 8'h00;

  typedef struct packed {
    logic we;
    logic re;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } reg_req_t;

endpackage

//--- verification/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import dds_tuning_pkg::*;
  localparam int unsigned CPM = 100;
  localparam logic [FTW_W-1:0] FR = 48'h0001_8000_0000;
  localparam logic [FTW_W-1:0] WA = 48'h0000_a000_0010;
  localparam logic [FTW_W-1:0] WB = 48'h0000_b123_4567;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  reg_req_t req = '0;
  loop_mode_t mode = MODE_FREE_RUN;
  logic [FTW_W-1:0] lf_word = '0;
  logic lf_valid = 1'b0;
  logic ref_sw = 1'b0;
  logic pin_clr = 1'b0;
  logic toggle = 1'b0;
  logic [DATA_W-1:0] rdata;
  logic rvalid;
  logic strobe;
  logic hvalid;
  logic [PHASE_W-1:0] phase;
  logic [FTW_W-1:0] tword;
  logic [DAC_W-1:0] dac;
  logic [FTW_W-1:0] v;
  logic [PHASE_W-1:0] p0;
  int failures = 0;
  int checked = 0;
  int n;

  dds_tuning_word_path #(.CYCLES_PER_MS(CPM)) u_dds_tuning_word_path (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .reg_req_i(req),
    .reg_rdata_o(rdata),
    .reg_rvalid_o(rvalid),
    .loop_mode_i(mode),
    .lf_word_i(lf_word),
    .lf_valid_i(lf_valid),
    .ref_switch_i(ref_sw),
    .mfp_clear_history_i(pin_clr),
    .phase_word_o(phase),
    .tuning_word_o(tword),
    .dac_current_code_o(dac),
    .history_strobe_o(strobe),
    .history_valid_o(hvalid)
  );

  initial begin
    forever #5 clk_i = ~clk_i;
  end

  // Alternating samples make the mean differ from every single sample.
  always @(negedge clk_i) begin
    if (toggle) begin
      lf_word <= lf_word ^ 48'h0000_0000_0004;
    end
  end

  task automatic check(input string nm, input logic [FTW_W-1:0] seen, input logic [FTW_W-1:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(negedge clk_i);
    req <= '{we: 1'b1, re: 1'b0, addr: a, wdata: d};
    @(negedge clk_i);
    req <= '0;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(negedge clk_i);
    req <= '{we: 1'b0, re: 1'b1, addr: a, wdata: BYTE_ZERO};
    @(negedge clk_i);
    req <= '0;
    d = rdata;
    check("rvalid", rvalid, 1'b1);
  endtask

  task automatic wrn(input logic [ADDR_W-1:0] a, input int nb, input logic [FTW_W-1:0] w);
    for (int i = 0; i < nb; i++) begin
      wr(a + ADDR_W'(i), w[8*i+:8]);
    end
  endtask

  task automatic rdn(input logic [ADDR_W-1:0] a, input int nb, output logic [FTW_W-1:0] w);
    logic [DATA_W-1:0] b;
    w = '0;
    for (int i = 0; i < nb; i++) begin
      rd(a + ADDR_W'(i), b);
      w[8*i+:8] = b;
    end
  endtask

  // A strobe that never comes ends the run as a failure.
  task automatic wait_strobe(output int c);
    c = 0;
    do begin
      @(negedge clk_i);
      c++;
    end while (strobe !== 1'b1 && c < 3000);
    if (strobe !== 1'b1) begin
      failures++;
      final_report();
    end
  endtask

  task automatic t_reset();
    check("tword", tword, '0);
    check("hvalid", hvalid, 1'b0);
    rdn(ADDR_CLAMP_UPPER, 6, v);
    check("clamps", v, 48'h0000_00ff_ffff);
    rdn(ADDR_INTERVAL, 4, v);
    check("interval_ctrl", v, 48'h0000_0000_0001);
    rdn(12'h400, 1, v);
    check("unmapped", v, '0);
    $display("done reset");
  endtask

  task automatic t_accum();
    wrn(ADDR_FREE_RUN, 6, FR);
    repeat (4) @(negedge clk_i);
    check("tword_free", tword, FR);
    p0 = phase;
    repeat (2) @(negedge clk_i);
    check("phase_step", phase, p0 + 16'h0003);
    p0 = phase;
    wrn(ADDR_PHASE_OFFSET, 2, 48'h0100);
    repeat (4) @(negedge clk_i);
    check("phase_offset", phase, p0 + 16'h010c);
    $display("done accum");
  endtask

  task automatic t_clamp();
    wrn(ADDR_CLAMP_UPPER, 3, 48'h00_0100);
    wrn(ADDR_CLAMP_LOWER, 3, 48'h00_0080);
    repeat (2) @(negedge clk_i);
    check("clamp_hi", tword, 48'h0001_00ff_ffff);
    mode <= MODE_CLOSED;
    lf_word <= '0;
    repeat (2) @(negedge clk_i);
    check("clamp_lo", tword, 48'h0000_8000_0000);
    lf_word <= 48'h0000_c000_1234;
    repeat (2) @(negedge clk_i);
    check("closed", tword, 48'h0000_c000_1234);
    wrn(ADDR_CLAMP_UPPER, 3, 48'hff_ffff);
    wrn(ADDR_CLAMP_LOWER, 3, 48'h00_0000);
    $display("done clamp");
  endtask

  task automatic t_fallback();
    wrn(ADDR_INTERVAL, 3, 48'h00_0100);
    wr(ADDR_HIST_CLEAR, 8'h04);
    lf_word <= WA;
    lf_valid <= 1'b1;
    @(negedge clk_i);
    lf_valid <= 1'b0;
    mode <= MODE_HOLDOVER;
    repeat (2) @(negedge clk_i);
    check("hvalid", hvalid, 1'b0);
    check("hold_free", tword, FR);
    wr(ADDR_HIST_CTRL, 8'h10);
    repeat (2) @(negedge clk_i);
    check("hold_last", tword, WA);
    wr(ADDR_HIST_CTRL, 8'h00);
    $display("done fallback");
  endtask

  task automatic t_history();
    wrn(ADDR_INTERVAL, 3, 48'h00_0001);
    mode <= MODE_CLOSED;
    lf_word <= WA;
    lf_valid <= 1'b1;
    wr(ADDR_HIST_CLEAR, 8'h04);
    toggle <= 1'b1;
    wait_strobe(n);
    check("hvalid", hvalid, 1'b1);
    @(negedge clk_i);
    check("strobe_pulse", strobe, 1'b0);
    rdn(ADDR_HIST_RESULT, 6, v);
    check("mean", (v == WA + 1) || (v == WA + 2), 1'b1);
    toggle <= 1'b0;
    @(negedge clk_i);
    lf_word <= WB;
    // The interval running when the word changed still holds old samples.
    wait_strobe(n);
    wait_strobe(n);
    wait_strobe(n);
    check("gap", n, CPM);
    rdn(ADDR_HIST_RESULT, 6, v);
    check("memoryless", v, WB);
    wr(ADDR_HIST_RESULT, 8'h55);
    rdn(ADDR_HIST_RESULT, 1, v);
    check("result_ro", v, WB[7:0]);
    mode <= MODE_HOLDOVER;
    repeat (2) @(negedge clk_i);
    check("hold_hist", tword, WB);
    $display("done history");
  endtask

  task automatic t_inter();
    mode <= MODE_CLOSED;
    wrn(ADDR_INTERVAL, 3, 48'h00_0008);
    wr(ADDR_HIST_CTRL, 8'h02);
    wr(ADDR_HIST_CLEAR, 8'h04);
    wait_strobe(n);
    wait_strobe(n);
    check("gap_2ms", n, 2 * CPM);
    wait_strobe(n);
    check("gap_4ms", n, 4 * CPM);
    wait_strobe(n);
    check("gap_8ms", n, 8 * CPM);
    $display("done intermediate");
  endtask

  task automatic t_switch();
    wr(ADDR_HIST_CTRL, 8'h08);
    ref_sw <= 1'b1;
    @(negedge clk_i);
    ref_sw <= 1'b0;
    repeat (3) @(negedge clk_i);
    check("persist", hvalid, 1'b1);
    wr(ADDR_HIST_CTRL, 8'h00);
    ref_sw <= 1'b1;
    @(negedge clk_i);
    ref_sw <= 1'b0;
    repeat (3) @(negedge clk_i);
    check("switch_erase", hvalid, 1'b0);
    wait_strobe(n);
    check("regain", hvalid, 1'b1);
    pin_clr <= 1'b1;
    repeat (6) @(negedge clk_i);
    check("pin_erase", hvalid, 1'b0);
    pin_clr <= 1'b0;
    $display("done switch");
  endtask

  task automatic t_dac();
    wr(ADDR_DAC_LO, 8'ha5);
    wr(ADDR_DAC_HI, 8'h03);
    @(negedge clk_i);
    check("dac", dac, 10'h3a5);
    rdn(ADDR_DAC_LO, 2, v);
    check("dac_rd", v, 48'h0000_0000_03a5);
    $display("done dac");
  endtask

  initial begin
    repeat (20) @(negedge clk_i);
    reset_n_i <= 1'b1;
    t_reset();
    t_accum();
    t_clamp();
    t_fallback();
    t_history();
    t_inter();
    t_switch();
    t_dac();
    final_report();
  end
endmodule
`default_nettype wire
